/* File: spc_map.vh */
// Constants for the serial port configuration block
`ifndef SPC_MAP_VH
`define SPC_MAP_VH
`define SPC_CLK_HZ       10000000
`define SPC_MS_PER_STEP  1
`define SPC_HZ_PER_KHZ   1000
`define SPC_BPS_9K6      9600
`define SPC_BPS_19K2     19200
`define SPC_BPS_38K4     38400
`define SPC_BPS_57K6     57600
`define SPC_BPS_115K2    115200
`define SPC_BAUD_9K6     3'h3
`define SPC_BAUD_19K2    3'h4
`define SPC_BAUD_38K4    3'h5
`define SPC_BAUD_57K6    3'h6
`define SPC_BAUD_115K2   3'h7
`define SPC_LEN_7        1'h0
`define SPC_LEN_8        1'h1
`define SPC_STOP_1       1'h0
`define SPC_STOP_2       1'h1
`define SPC_PAR_NONE     2'h0
`define SPC_PAR_EVEN     2'h1
`define SPC_PAR_ODD      2'h2
`define SPC_PROTO_NATIVE 1'h0
`define SPC_PROTO_MODBUS 1'h1
`define SPC_WAIT_MAX     7'h63
`define SPC_WAIT_DFLT    7'h05
`define SPC_WAIT_FIXED_A 7'h00
`define SPC_DFLT_BAUD    `SPC_BAUD_9K6
`define SPC_DFLT_LEN     `SPC_LEN_7
`define SPC_DFLT_STOP    `SPC_STOP_2
`define SPC_DFLT_PAR     `SPC_PAR_EVEN
`define SPC_DFLT_PROTO   `SPC_PROTO_NATIVE
`define SPC_DIV_W        16
`define SPC_FIFO_DEPTH   8
`endif

/* File: spc_fifo.v */
// Synchronous FIFO for outgoing response characters
`timescale 1ns/1ps
module spc_fifo #(
  parameter W     = 8,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire [W-1:0] i_data,
  input  wire         i_valid,
  output wire         o_ready,
  output wire [W-1:0] o_data,
  output wire         o_valid,
  input  wire         i_ready
);
  // Last slot index, cut to pointer width after the subtraction, not before
  localparam [31:0] LAST32 = DEPTH - 1;
  reg  [W-1:0] mem_r [0:DEPTH-1];
  reg  [AW-1:0] wr_r;
  reg  [AW-1:0] rd_r;
  reg  [AW:0]   cnt_r;
  wire          push_w = i_valid & o_ready;
  wire          pop_w  = o_valid & i_ready;
  assign o_ready = (cnt_r != DEPTH[AW:0]);
  assign o_valid = (cnt_r != {(AW+1){1'b0}});
  assign o_data  = mem_r[rd_r];
  always @(posedge i_clk)
  begin
    if (push_w)
    begin
      mem_r[wr_r] <= i_data;
    end
  end
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      wr_r  <= {AW{1'b0}};
      rd_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push_w)
        wr_r <= (wr_r == LAST32[AW-1:0]) ? {AW{1'b0}} : wr_r + 1'b1;
      if (pop_w)
        rd_r <= (rd_r == LAST32[AW-1:0]) ? {AW{1'b0}} : rd_r + 1'b1;
      if (push_w & ~pop_w)
        cnt_r <= cnt_r + 1'b1;
      else if (pop_w & ~push_w)
        cnt_r <= cnt_r - 1'b1;
    end
  end
endmodule

/* File: spc_tick.v */
// Restartable clock divider giving one-cycle enable pulses
`timescale 1ns/1ps
module spc_tick #(
  parameter W = 16
) (
  input  wire         i_clk,
  input  wire         i_rst,
  input  wire         i_restart,
  input  wire         i_half,
  input  wire [W-1:0] i_div,
  output reg          o_tick
);
  reg [W-1:0] cnt_r;
  always @(posedge i_clk)
  begin
    if (i_rst | i_restart)
    begin
      // Half start lets a receiver land in mid-bit
      cnt_r  <= i_half ? (i_div >> 1) : {W{1'b0}};
      o_tick <= 1'b0;
    end
    else if (cnt_r >= i_div - {{(W-1){1'b0}}, 1'b1})
    begin
      cnt_r  <= {W{1'b0}};
      o_tick <= 1'b1;
    end
    else
    begin
      cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
      o_tick <= 1'b0;
    end
  end
endmodule

/* File: spc_top.v */
// Two RS-485 serial ports: fixed port A, reset-latched configurable port B
// Operation
// - Port A always runs 38.4 kbps, seven data bits, two stop bits, even parity.
// - Port B rate code 3..7 selects 9.6 to 115.2 kbps; code 3 default.
// - Port B length code 0 gives seven bits, 1 gives eight bits.
// - Port B stop code 0 gives one stop bit, 1 gives two.
// - Port B parity code 0 none, 1 even, 2 odd; even default.
// - Port B turnaround wait 0 to 99 ms in 1 ms steps, default 5.
// - Port B protocol code 0 native framed, 1 Modbus; host keeps it 0; code 1 only sets o_b_proto_modbus, framing stays native.
// - Changed serial settings only take effect at the next reset.
// - Wait the turnaround time before driving the line and transmitting.
`timescale 1ns/1ps
`include "spc_map.vh"
module spc_top #(
  parameter MS_CYCLES  = `SPC_CLK_HZ / `SPC_HZ_PER_KHZ * `SPC_MS_PER_STEP,
  parameter FIFO_DEPTH = `SPC_FIFO_DEPTH
) (
  input  wire       i_clk,
  input  wire       i_rst,
  input  wire [2:0] i_b_baud_code,
  input  wire       i_b_len_code,
  input  wire       i_b_stop_code,
  input  wire [1:0] i_b_par_code,
  input  wire [6:0] i_b_wait_ms,
  input  wire       i_b_proto_code,
  output wire       o_b_proto_modbus,
  output wire       o_b_cfg_fault,
  input  wire       i_a_rxd,
  output wire       o_a_txd,
  output wire       o_a_de,
  input  wire [7:0] i_a_tx_data,
  input  wire       i_a_tx_valid,
  output wire       o_a_tx_ready,
  output wire       o_a_busy,
  output wire [7:0] o_a_rx_data,
  output wire       o_a_rx_valid,
  output wire       o_a_rx_perr,
  output wire       o_a_rx_ferr,
  input  wire       i_b_rxd,
  output wire       o_b_txd,
  output wire       o_b_de,
  input  wire [7:0] i_b_tx_data,
  input  wire       i_b_tx_valid,
  output wire       o_b_tx_ready,
  output wire       o_b_busy,
  output wire [7:0] o_b_rx_data,
  output wire       o_b_rx_valid,
  output wire       o_b_rx_perr,
  output wire       o_b_rx_ferr
);
  localparam DW = `SPC_DIV_W;
  localparam [31:0] DIV32_9K6   = (`SPC_CLK_HZ + `SPC_BPS_9K6 / 2) / `SPC_BPS_9K6;
  localparam [31:0] DIV32_19K2  = (`SPC_CLK_HZ + `SPC_BPS_19K2 / 2) / `SPC_BPS_19K2;
  localparam [31:0] DIV32_38K4  = (`SPC_CLK_HZ + `SPC_BPS_38K4 / 2) / `SPC_BPS_38K4;
  localparam [31:0] DIV32_57K6  = (`SPC_CLK_HZ + `SPC_BPS_57K6 / 2) / `SPC_BPS_57K6;
  localparam [31:0] DIV32_115K2 = (`SPC_CLK_HZ + `SPC_BPS_115K2 / 2) / `SPC_BPS_115K2;
  localparam [31:0] MS32        = MS_CYCLES;
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_WAIT = 3'h1;
  localparam [2:0] ST_STRT = 3'h2;
  localparam [2:0] ST_DATA = 3'h3;
  localparam [2:0] ST_PAR  = 3'h4;
  localparam [2:0] ST_STOP = 3'h5;

  // Parity bit for a character; odd flips the even result
  function spc_parity;
    input [7:0] d;
    input       len8;
    input       odd;
    begin
      spc_parity = (^(len8 ? d : {1'b0, d[6:0]})) ^ odd;
    end
  endfunction

  // Active port B settings, caught only while reset is held
  reg [DW-1:0] cfg_div_r;
  reg          cfg_len8_r;
  reg          cfg_two_r;
  reg          cfg_pen_r;
  reg          cfg_podd_r;
  reg [6:0]    cfg_wait_r;
  reg          cfg_proto_r;
  reg          cfg_fault_r;
  reg [DW-1:0] cfg_div_nxt;
  reg          cfg_pen_nxt;
  reg          cfg_podd_nxt;
  reg [6:0]    cfg_wait_nxt;
  reg          cfg_fault_nxt;

  always @*
  begin
    cfg_fault_nxt = 1'b0;
    case (i_b_baud_code)
      `SPC_BAUD_9K6:   cfg_div_nxt = DIV32_9K6[DW-1:0];
      `SPC_BAUD_19K2:  cfg_div_nxt = DIV32_19K2[DW-1:0];
      `SPC_BAUD_38K4:  cfg_div_nxt = DIV32_38K4[DW-1:0];
      `SPC_BAUD_57K6:  cfg_div_nxt = DIV32_57K6[DW-1:0];
      `SPC_BAUD_115K2: cfg_div_nxt = DIV32_115K2[DW-1:0];
      default:
      begin
        cfg_div_nxt   = DIV32_9K6[DW-1:0];
        cfg_fault_nxt = 1'b1;
      end
    endcase
    case (i_b_par_code)
      `SPC_PAR_NONE:
      begin
        cfg_pen_nxt  = 1'b0;
        cfg_podd_nxt = 1'b0;
      end
      `SPC_PAR_EVEN:
      begin
        cfg_pen_nxt  = 1'b1;
        cfg_podd_nxt = 1'b0;
      end
      `SPC_PAR_ODD:
      begin
        cfg_pen_nxt  = 1'b1;
        cfg_podd_nxt = 1'b1;
      end
      default:
      begin
        cfg_pen_nxt   = 1'b1;
        cfg_podd_nxt  = 1'b0;
        cfg_fault_nxt = 1'b1;
      end
    endcase
    // Out-of-range codes fall back to the defaults rather than locking up
    if (i_b_wait_ms > `SPC_WAIT_MAX)
    begin
      cfg_wait_nxt  = `SPC_WAIT_DFLT;
      cfg_fault_nxt = 1'b1;
    end
    else
    begin
      cfg_wait_nxt = i_b_wait_ms;
    end
  end

  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      cfg_div_r   <= cfg_div_nxt;
      cfg_len8_r  <= i_b_len_code;
      cfg_two_r   <= i_b_stop_code;
      cfg_pen_r   <= cfg_pen_nxt;
      cfg_podd_r  <= cfg_podd_nxt;
      cfg_wait_r  <= cfg_wait_nxt;
      cfg_proto_r <= i_b_proto_code;
      cfg_fault_r <= cfg_fault_nxt;
    end
  end

  // Only the native framed protocol is carried; Modbus is flagged only
  assign o_b_proto_modbus = cfg_proto_r;
  assign o_b_cfg_fault    = cfg_fault_r;

  wire [1:0]  rxd_w  = {i_b_rxd, i_a_rxd};
  wire [15:0] tdat_w = {i_b_tx_data, i_a_tx_data};
  wire [1:0]  tval_w = {i_b_tx_valid, i_a_tx_valid};
  wire [1:0]  trdy_w;
  wire [1:0]  txd_w;
  wire [1:0]  de_w;
  wire [1:0]  busy_w;
  wire [15:0] rdat_w;
  wire [1:0]  rval_w;
  wire [1:0]  perr_w;
  wire [1:0]  ferr_w;

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : port
      // Port A settings are constants and ignore every code
      wire [DW-1:0] div_w  = (g == 0) ? DIV32_38K4[DW-1:0] : cfg_div_r;
      wire          len8_w = (g == 0) ? `SPC_LEN_7 : cfg_len8_r;
      wire          two_w  = (g == 0) ? `SPC_STOP_2 : cfg_two_r;
      wire          pen_w  = (g == 0) ? 1'b1 : cfg_pen_r;
      wire          podd_w = (g == 0) ? 1'b0 : cfg_podd_r;
      wire [6:0]    wait_w = (g == 0) ? `SPC_WAIT_FIXED_A : cfg_wait_r;
      wire [2:0]    last_w = len8_w ? 3'h7 : 3'h6;
      wire [7:0]    f_data;
      wire          f_valid;
      wire          t_tick;
      wire          r_tick;
      wire          m_tick;
      reg  [2:0]    tst_r;
      reg  [7:0]    tsh_r;
      reg  [2:0]    tbit_r;
      reg           tstop_r;
      reg  [6:0]    ms_r;
      reg           txd_r;
      reg           de_r;
      reg           s1_r;
      reg           s2_r;
      reg  [2:0]    rst_r;
      reg  [7:0]    rsh_r;
      reg  [2:0]    rbit_r;
      reg           rpar_r;
      reg  [7:0]    rdat_r;
      reg           rval_r;
      reg           perr_r;
      reg           ferr_r;
      wire          last_stop_w = (tstop_r == two_w);
      wire          go_w  = (tst_r == ST_WAIT) && (ms_r == 7'h00);
      wire          nxt_w = (tst_r == ST_STOP) && t_tick && last_stop_w;
      wire          pop_w = f_valid & (go_w | nxt_w);
      wire          r_go  = (rst_r == ST_IDLE) && !de_r && !s2_r;
      wire [7:0]    rchr_w = len8_w ? rsh_r : {1'b0, rsh_r[7:1]};

      spc_fifo #(.W(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .i_clk   (i_clk),
        .i_rst   (i_rst),
        .i_data  (tdat_w[g*8 +: 8]),
        .i_valid (tval_w[g]),
        .o_ready (trdy_w[g]),
        .o_data  (f_data),
        .o_valid (f_valid),
        .i_ready (pop_w)
      );
      spc_tick #(.W(DW)) u_ttick (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_restart (go_w),
        .i_half    (1'b0),
        .i_div     (div_w),
        .o_tick    (t_tick)
      );
      spc_tick #(.W(DW)) u_rtick (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_restart (r_go),
        .i_half    (1'b1),
        .i_div     (div_w),
        .o_tick    (r_tick)
      );
      spc_tick #(.W(DW)) u_mtick (
        .i_clk     (i_clk),
        .i_rst     (i_rst),
        .i_restart (tst_r == ST_IDLE),
        .i_half    (1'b0),
        .i_div     (MS32[DW-1:0]),
        .o_tick    (m_tick)
      );

      always @(posedge i_clk)
      begin
        if (i_rst)
        begin
          tst_r   <= ST_IDLE;
          tsh_r   <= 8'h00;
          tbit_r  <= 3'h0;
          tstop_r <= 1'b0;
          ms_r    <= 7'h00;
          txd_r   <= 1'b1;
          de_r    <= 1'b0;
        end
        else
        begin
          case (tst_r)
            ST_IDLE:
            begin
              if (f_valid)
              begin
                tst_r <= ST_WAIT;
                ms_r  <= wait_w;
              end
            end
            ST_WAIT:
            begin
              if (go_w)
              begin
                tst_r <= ST_STRT;
                tsh_r <= f_data;
                de_r  <= 1'b1;
                txd_r <= 1'b0;
              end
              else if (m_tick)
              begin
                ms_r <= ms_r - 7'h01;
              end
            end
            ST_STRT:
            begin
              if (t_tick)
              begin
                tst_r  <= ST_DATA;
                txd_r  <= tsh_r[0];
                tbit_r <= 3'h0;
              end
            end
            ST_DATA:
            begin
              if (t_tick)
              begin
                tbit_r <= tbit_r + 3'h1;
                if (tbit_r == last_w)
                begin
                  tst_r   <= pen_w ? ST_PAR : ST_STOP;
                  txd_r   <= pen_w ? spc_parity(tsh_r, len8_w, podd_w) : 1'b1;
                  tstop_r <= 1'b0;
                end
                else
                begin
                  txd_r <= tsh_r[tbit_r + 3'h1];
                end
              end
            end
            ST_PAR:
            begin
              if (t_tick)
              begin
                tst_r   <= ST_STOP;
                txd_r   <= 1'b1;
                tstop_r <= 1'b0;
              end
            end
            ST_STOP:
            begin
              if (t_tick)
              begin
                if (!last_stop_w)
                begin
                  tstop_r <= 1'b1;
                end
                else if (f_valid)
                begin
                  // Queued bytes follow back to back without a new wait
                  tst_r <= ST_STRT;
                  tsh_r <= f_data;
                  txd_r <= 1'b0;
                end
                else
                begin
                  tst_r <= ST_IDLE;
                  de_r  <= 1'b0;
                end
              end
            end
            default:
            begin
              tst_r <= ST_IDLE;
              de_r  <= 1'b0;
              txd_r <= 1'b1;
            end
          endcase
        end
      end

      // Receiver; starts are ignored while driving, so no own echo
      always @(posedge i_clk)
      begin
        if (i_rst)
        begin
          s1_r   <= 1'b1;
          s2_r   <= 1'b1;
          rst_r  <= ST_IDLE;
          rsh_r  <= 8'h00;
          rbit_r <= 3'h0;
          rpar_r <= 1'b0;
          rdat_r <= 8'h00;
          rval_r <= 1'b0;
          perr_r <= 1'b0;
          ferr_r <= 1'b0;
        end
        else
        begin
          s1_r   <= rxd_w[g];
          s2_r   <= s1_r;
          rval_r <= 1'b0;
          case (rst_r)
            ST_IDLE:
            begin
              if (r_go)
                rst_r <= ST_STRT;
            end
            ST_STRT:
            begin
              if (r_tick)
              begin
                rst_r  <= s2_r ? ST_IDLE : ST_DATA;
                rbit_r <= 3'h0;
              end
            end
            ST_DATA:
            begin
              if (r_tick)
              begin
                rsh_r  <= {s2_r, rsh_r[7:1]};
                rbit_r <= rbit_r + 3'h1;
                if (rbit_r == last_w)
                  rst_r <= pen_w ? ST_PAR : ST_STOP;
              end
            end
            ST_PAR:
            begin
              if (r_tick)
              begin
                rpar_r <= s2_r;
                rst_r  <= ST_STOP;
              end
            end
            ST_STOP:
            begin
              // Only the first stop bit is checked
              if (r_tick)
              begin
                rst_r  <= ST_IDLE;
                rdat_r <= rchr_w;
                rval_r <= 1'b1;
                ferr_r <= ~s2_r;
                perr_r <= pen_w & (rpar_r != spc_parity(rchr_w, len8_w, podd_w));
              end
            end
            default:
            begin
              rst_r <= ST_IDLE;
            end
          endcase
        end
      end

      assign txd_w[g]         = txd_r;
      assign de_w[g]          = de_r;
      assign busy_w[g]        = (tst_r != ST_IDLE);
      assign rdat_w[g*8 +: 8] = rdat_r;
      assign rval_w[g]        = rval_r;
      assign perr_w[g]        = perr_r;
      assign ferr_w[g]        = ferr_r;
    end
  endgenerate

  assign o_a_txd      = txd_w[0];
  assign o_a_de       = de_w[0];
  assign o_a_tx_ready = trdy_w[0];
  assign o_a_busy     = busy_w[0];
  assign o_a_rx_data  = rdat_w[7:0];
  assign o_a_rx_valid = rval_w[0];
  assign o_a_rx_perr  = perr_w[0];
  assign o_a_rx_ferr  = ferr_w[0];
  assign o_b_txd      = txd_w[1];
  assign o_b_de       = de_w[1];
  assign o_b_tx_ready = trdy_w[1];
  assign o_b_busy     = busy_w[1];
  assign o_b_rx_data  = rdat_w[15:8];
  assign o_b_rx_valid = rval_w[1];
  assign o_b_rx_perr  = perr_w[1];
  assign o_b_rx_ferr  = ferr_w[1];
endmodule

/* File: spc_top_sva.sv */
// Concurrent checks on the ports of the serial port configuration top
`timescale 1ns/1ps
module spc_top_sva #(
  parameter MS_CYCLES  = 10000,
  parameter FIFO_DEPTH = 8
) (
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [6:0] i_b_wait_ms,
  input wire logic       i_b_proto_code,
  input wire logic       o_b_proto_modbus,
  input wire logic       o_b_cfg_fault,
  input wire logic       o_a_txd,
  input wire logic       o_a_de,
  input wire logic       o_a_busy,
  input wire logic       o_b_txd,
  input wire logic       o_b_de,
  input wire logic       o_b_busy
);
  logic [6:0] wait_r;
  int         cnt_r;
  int         wait_eff;

  // Own copy of the latched wait, since the design's copy is not visible here
  always @(posedge i_clk)
  begin
    if (i_rst)
      wait_r <= i_b_wait_ms;
    cnt_r <= (o_b_busy && !o_b_de) ? cnt_r + 1 : 0;
  end
  assign wait_eff = (wait_r > 7'h63) ? 5 : wait_r;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_a_launch;
    !o_a_de ##1 (o_a_de && !o_a_txd);
  endsequence
  sequence s_b_hold;
    !o_b_de [*8];
  endsequence

  a_a_no_wait: assert property ($rose(o_a_busy) |-> ##[0:1] s_a_launch)
    else $error("port A did not start right after its zero wait");
  a_b_turnaround: assert property ($rose(o_b_de) |-> cnt_r >= wait_eff * MS_CYCLES
    && cnt_r <= wait_eff * (MS_CYCLES + 1) + 4)
    else $error("port B turnaround wait has the wrong length");
  a_b_hold_off: assert property ($rose(o_b_busy) && wait_eff != 0 |-> s_b_hold)
    else $error("port B drove the line without waiting");
  a_b_start_low: assert property ($rose(o_b_de) |-> !o_b_txd [*8])
    else $error("port B driver enabled without a start bit");
  a_drv_release: assert property ((!o_a_busy -> !o_a_de) && (!o_b_busy -> !o_b_de))
    else $error("line driver left on while transmitter idle");
  a_line_idle: assert property ((!o_a_de -> o_a_txd) && (!o_b_de -> o_b_txd))
    else $error("transmit line not high while driver is off");
  a_cfg_frozen: assert property (!$past(i_rst) |-> $stable(o_b_proto_modbus)
    && $stable(o_b_cfg_fault))
    else $error("configuration outputs changed outside reset");
  a_proto_latch: assert property ($fell(i_rst) |-> o_b_proto_modbus == $past(i_b_proto_code))
    else $error("protocol code not latched at reset");
endmodule

bind spc_top spc_top_sva #(.MS_CYCLES(MS_CYCLES), .FIFO_DEPTH(FIFO_DEPTH)) i_spc_top_sva (
  .i_clk(i_clk), .i_rst(i_rst), .i_b_wait_ms(i_b_wait_ms), .i_b_proto_code(i_b_proto_code),
  .o_b_proto_modbus(o_b_proto_modbus), .o_b_cfg_fault(o_b_cfg_fault), .o_a_txd(o_a_txd),
  .o_a_de(o_a_de), .o_a_busy(o_a_busy), .o_b_txd(o_b_txd), .o_b_de(o_b_de), .o_b_busy(o_b_busy));

/* File: spc_host_model.sv */
// Host computer model on both multipoint lines
`timescale 1ns/1ps
module spc_host_model (
  input  wire logic       i_clk,
  input  wire logic [1:0] i_txd,
  input  wire logic [1:0] i_de,
  output logic      [1:0] o_rxd
);
  // Biased line rests high between characters
  initial o_rxd = 2'h3;

  task automatic put_char(input int p, input logic [7:0] d, input int div, nb, par, stop,
                          input bit flip);
    logic [11:0] f;
    int          n;
    begin
      f = 12'hfff;
      f[0] = 1'b0;
      for (int i = 0; i < nb; i++) f[i+1] = d[i];
      n = nb + 1;
      if (par != 0)
      begin
        f[n] = ^(d & ((nb == 8) ? 8'hff : 8'h7f)) ^ (par == 2) ^ flip;
        n++;
      end
      n = n + stop;
      @(negedge i_clk);
      for (int i = 0; i < n; i++)
      begin
        o_rxd[p] = f[i];
        repeat (div) @(negedge i_clk);
      end
    end
  endtask

  // Decode one character at mid-bit; ok also needs the driver held to the stop bits
  task automatic get_char(input int p, div, nb, par, stop, output logic [7:0] d, output bit ok);
    int t;
    begin
      d = 8'h00;
      ok = 1'b0;
      t = 0;
      while (!(i_de[p] === 1'b1 && i_txd[p] === 1'b0) && t < 40000)
      begin
        @(negedge i_clk);
        t++;
      end
      if (t < 40000)
      begin
        repeat (div / 2) @(negedge i_clk);
        ok = (i_txd[p] === 1'b0);
        for (int i = 0; i < nb; i++)
        begin
          repeat (div) @(negedge i_clk);
          d[i] = i_txd[p];
        end
        if (par != 0)
        begin
          repeat (div) @(negedge i_clk);
          ok &= (i_txd[p] === (^d ^ (par == 2)));
        end
        for (int i = 0; i < stop; i++)
        begin
          repeat (div) @(negedge i_clk);
          ok &= (i_txd[p] === 1'b1) && (i_de[p] === 1'b1);
        end
      end
    end
  endtask
endmodule

/* File: tb_spc_top.sv */
// Self-checking testbench for the serial port configuration top
`timescale 1ns/1ps
module tb_spc_top;
  logic       i_clk, i_rst, len, stp, proto;
  logic [2:0] baud;
  logic [1:0] par, tx_v;
  logic [6:0] wt;
  logic [7:0] tx_d [2];
  wire  [1:0] rxd, txd, de, rdy, busy, rxv, perr, ferr;
  wire  [7:0] rx_d [2];
  wire        modbus, fault;
  int         num_errors, n_checks;
  // baud, len, stop, parity, wait, protocol, bytes offered
  int cfg [6][7] = '{'{3, 0, 1, 1, 5, 0, 1}, '{4, 1, 0, 0, 1, 0, 2}, '{5, 1, 1, 2, 2, 0, 2},
                     '{6, 0, 0, 2, 99, 0, 2}, '{7, 1, 0, 1, 3, 0, 9}, '{2, 0, 1, 3, 100, 1, 1}};

  spc_top #(.MS_CYCLES(20), .FIFO_DEPTH(8)) i_spc_top (
    .i_clk(i_clk), .i_rst(i_rst), .i_b_baud_code(baud), .i_b_len_code(len),
    .i_b_stop_code(stp), .i_b_par_code(par), .i_b_wait_ms(wt), .i_b_proto_code(proto),
    .o_b_proto_modbus(modbus), .o_b_cfg_fault(fault),
    .i_a_rxd(rxd[0]), .o_a_txd(txd[0]), .o_a_de(de[0]), .i_a_tx_data(tx_d[0]),
    .i_a_tx_valid(tx_v[0]), .o_a_tx_ready(rdy[0]), .o_a_busy(busy[0]), .o_a_rx_data(rx_d[0]),
    .o_a_rx_valid(rxv[0]), .o_a_rx_perr(perr[0]), .o_a_rx_ferr(ferr[0]),
    .i_b_rxd(rxd[1]), .o_b_txd(txd[1]), .o_b_de(de[1]), .i_b_tx_data(tx_d[1]),
    .i_b_tx_valid(tx_v[1]), .o_b_tx_ready(rdy[1]), .o_b_busy(busy[1]), .o_b_rx_data(rx_d[1]),
    .o_b_rx_valid(rxv[1]), .o_b_rx_perr(perr[1]), .o_b_rx_ferr(ferr[1]));

  spc_host_model i_spc_host_model (.i_clk(i_clk), .i_txd(txd), .i_de(de), .o_rxd(rxd));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  function automatic logic [7:0] pat(input int i);
    return 8'h5a + 8'h33 * i[7:0];
  endfunction

  function automatic int div_of(input int code);
    case (code)
      4: return 521;
      5: return 260;
      6: return 174;
      7: return 87;
      default: return 1042;
    endcase
  endfunction

  task automatic check(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic end_sim;
    if (num_errors == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic do_reset(input int b, l, s, p, w, pr);
    @(negedge i_clk);
    // Rate only ever comes from the code port; no switch position is driven
    {baud, len, stp, par, wt, proto} = {b[2:0], l[0], s[0], p[1:0], w[6:0], pr[0]};
    i_rst = 1'b1;
    repeat (2) @(negedge i_clk);
    i_rst = 1'b0;
  endtask

  // Offer n bytes back to back; the line side receives what should have been taken
  task automatic tx_chk(input int p, n, div, nb, pa, st, exp_acc);
    int         acc, t;
    logic       r;
    logic [7:0] d;
    bit         ok;
    begin
      acc = 0;
      t = 0;
      fork
        begin
          for (int i = 0; i < n; i++)
          begin
            @(negedge i_clk);
            tx_v[p] = 1'b1;
            tx_d[p] = pat(i);
            r = rdy[p];
            @(posedge i_clk);
            if (r === 1'b1) acc++;
          end
          @(negedge i_clk);
          tx_v[p] = 1'b0;
        end
        for (int i = 0; i < exp_acc; i++)
        begin
          i_spc_host_model.get_char(p, div, nb, pa, st, d, ok);
          check("tx char", {ok, d}, {1'b1, pat(i) & ((nb == 8) ? 8'hff : 8'h7f)});
        end
      join
      check("bytes taken", acc, exp_acc);
      while (busy[p] !== 1'b0 && t < 4000)
      begin
        @(negedge i_clk);
        t++;
      end
      check("line released", {de[p], txd[p]}, 2'b01);
    end
  endtask

  task automatic rx_chk(input int p, input logic [7:0] d, input int div, nb, pa, st, input bit flip);
    int t;
    begin
      t = 0;
      fork
        i_spc_host_model.put_char(p, d, div, nb, pa, st, flip);
        while (rxv[p] !== 1'b1 && t < 20000)
        begin
          @(negedge i_clk);
          t++;
        end
      join
      check("rx char", {t < 20000, rx_d[p], perr[p], ferr[p]},
            {1'b1, d & ((nb == 8) ? 8'hff : 8'h7f), pa != 0 && flip, 1'b0});
    end
  endtask

  initial
  begin
    repeat (98000) @(posedge i_clk);
    num_errors++;
    end_sim;
  end

  initial
  begin
    int dv, nb, st, pe;
    {baud, len, stp, par, wt, proto} = {3'h3, 1'h0, 1'h1, 2'h1, 7'h05, 1'h0};
    i_rst = 1'b1;
    tx_v = 2'h0;
    tx_d[0] = 8'h00;
    tx_d[1] = 8'h00;
    num_errors = 0;
    n_checks = 0;
    // Count rising edges so the clock's first settle at time zero is not a falling one
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    i_rst = 1'b0;
    tx_chk(0, 2, 260, 7, 1, 2, 2);
    rx_chk(0, 8'hc5, 260, 7, 1, 2, 1'b0);
    rx_chk(0, 8'h3a, 260, 7, 1, 2, 1'b1);
    for (int r = 0; r < 6; r++)
    begin
      // Last row sets the foreign protocol only to see the latch; a real host keeps it 0
      do_reset(cfg[r][0], cfg[r][1], cfg[r][2], cfg[r][3], cfg[r][4], cfg[r][5]);
      check("cfg flags", {modbus, fault}, {cfg[r][5][0], r == 5});
      // Codes moved outside reset must not reach the running port
      if (r == 4) {baud, par, wt} = {3'h3, 2'h0, 7'h00};
      dv = div_of(cfg[r][0]);
      nb = cfg[r][1] ? 8 : 7;
      st = cfg[r][2] ? 2 : 1;
      pe = (cfg[r][3] == 3) ? 1 : cfg[r][3];
      tx_chk(1, cfg[r][6], dv, nb, pe, st, (cfg[r][6] > 8) ? 8 : cfg[r][6]);
      if (r < 5) rx_chk(1, pat(r + 7), dv, nb, pe, st, 1'b0);
      if (r == 4) tx_chk(0, 1, 260, 7, 1, 2, 1);
    end
    @(negedge i_clk);
    {baud, proto, wt} = {3'h7, 1'h0, 7'h05};
    repeat (4) @(negedge i_clk);
    check("cfg frozen", {modbus, fault}, 2'h3);
    end_sim;
  end
endmodule
